// >>> rtl/ftf_defs.svh
// Constants of the fall-through FIFO flag block: sizes, offsets, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef FTF_DEFS_SVH
`define FTF_DEFS_SVH

`define FTF_DATA_W 18
`define FTF_ADDR_W 11
`define FTF_PTR_W 12
`define FTF_MEM_WORDS 2048
`define FTF_OFS_W 11
`define FTF_PIN_W 26
// Memory plus output register.
`define FTF_DEPTH 12'h801
`define FTF_HALF_MARK 12'h402
`define FTF_AE_ADD 12'h002

// Default offsets indexed by {load select, select hi, select lo}.
`define FTF_OFS_LLL 11'h07F
`define FTF_OFS_LLH 11'h0FF
`define FTF_OFS_LHL 11'h1FF
`define FTF_OFS_LHH 11'h03F
`define FTF_OFS_HLL 11'h3FF
`define FTF_OFS_HLH 11'h00F
`define FTF_OFS_HHL 11'h01F
`define FTF_OFS_HHH 11'h007

// Register byte offsets.
`define FTF_REG_STATUS 8'h00
`define FTF_REG_MASK 8'h04
`define FTF_REG_CONFIG 8'h08
`define FTF_REG_LEVEL 8'h0C
`define FTF_EV_W 4
`define FTF_EV_WR_REJ 0
`define FTF_EV_RD_REJ 1
`define FTF_EV_FULL 2
`define FTF_EV_EMPTY 3
`define FTF_CFG_OFS_LSB 16
`define FTF_LVL_FLAG_LSB 16

`define FTF_RST_MASK 4'h0
`define FTF_RST_OFS 11'h07F
`define FTF_RESP_OKAY 2'h0
`define FTF_RESP_SLVERR 2'h2

`endif

// >>> rtl/ftf_pkg.sv
// Types shared by the fall-through FIFO flag block.
// Assumes ftf_defs.svh is in the include path.
`include "ftf_defs.svh"

package ftf_pkg;

  typedef struct packed {
    logic wclk;
    logic rclk;
    logic wen_n;
    logic ren_n;
    logic offset_load_select;
    logic default_offset_sel_hi;
    logic default_offset_sel_lo;
    logic fall_through_select;
    logic [`FTF_DATA_W-1:0] write_data_bus;
  } ftf_pins_t;

  typedef struct packed {
    logic or_n;
    logic input_ready_n;
    logic almost_empty_flag_n;
    logic half_full_flag_n;
    logic almost_full_flag_n;
  } ftf_flags_t;

  typedef struct packed {
    logic fall_through_mode;
    logic serial_load_mode;
    logic [`FTF_OFS_W-1:0] offset;
  } ftf_straps_t;

  function automatic logic [`FTF_PTR_W-1:0] ftf_to_gray(input logic [`FTF_PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [`FTF_PTR_W-1:0] ftf_from_gray(input logic [`FTF_PTR_W-1:0] g);
    logic [`FTF_PTR_W-1:0] b;
    b[`FTF_PTR_W-1] = g[`FTF_PTR_W-1];
    for (int i = `FTF_PTR_W-2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// >>> rtl/ftf_mem.sv
// Word store of the FIFO: one write port, one read port, registered read data.
// Assumes both ports are clocked by the system clock.
`timescale 1ns/100ps
`default_nettype none
`include "ftf_defs.svh"

module ftf_mem (
  input wire logic clk, // System clock.
  input wire logic we, // Write strobe.
  input wire logic [`FTF_ADDR_W-1:0] waddr, // Write address.
  input wire logic [`FTF_DATA_W-1:0] wdata, // Write data.
  input wire logic re, // Read strobe.
  input wire logic [`FTF_ADDR_W-1:0] raddr, // Read address.
  output logic [`FTF_DATA_W-1:0] rdata // Read data, one cycle after re.
);

  logic [`FTF_DATA_W-1:0] mem [0:`FTF_MEM_WORDS-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule
`default_nettype wire

// >>> rtl/ftf_fifo.sv
// Fall-through FIFO with status flags, 2048 memory words plus output register.
// Assumes pins are asynchronous to CLK_SYS and clocks run well below its rate.
// Functional notes
// RQ1 - A word is stored at each write clock rise while write enable is low.
// RQ2 - First word into an empty FIFO drives output ready low.
// RQ3 - Almost-empty goes high once stored words reach empty offset plus two.
// RQ4 - Half-full goes low once written words reach half depth plus two.
// RQ5 - Almost-full goes low once writes reach depth minus full offset.
// RQ6 - When full, input ready goes high and writes are ignored.
// RQ7 - Effective depth is memory plus one word: 2049 words.
// RQ8 - Load pin and two selects choose one of eight default offsets at reset.
// RQ9 - Outside logic keeps load pin high while moving data words.
// RQ10 - Fall-through select high during master reset picks fall-through timing; the code only records the choice in the config register.
// RQ11 - First word reaches the read bus after three read clock rises.
// RQ12 - Output ready passes three read stages, input ready two write stages.
// RQ13 - Load pin high at reset selects serial, low selects parallel loading; the code only records the choice in the config register.
// RQ14 - Reads lower the count; flags release; reads when empty are ignored.
// RQ15 - Pointers cross between domains through gray-coded synchronisers.
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ftf_defs.svh"

module ftf_fifo
  import ftf_pkg::*;
(
  input wire logic CLK_SYS, // System clock, 100 MHz.
  input wire logic RST_N, // Master reset, synchronous, active low.
  input wire logic WCLK, // Write clock pin.
  input wire logic WEN_N, // Write enable, active low.
  input wire logic [`FTF_DATA_W-1:0] WRITE_DATA_BUS, // Write data.
  input wire logic RCLK, // Read clock pin.
  input wire logic REN_N, // Read enable, active low.
  input wire logic OFFSET_LOAD_SELECT, // Load pin, strap at reset.
  input wire logic DEFAULT_OFFSET_SEL_HI, // Offset select high, strap.
  input wire logic DEFAULT_OFFSET_SEL_LO, // Offset select low, strap.
  input wire logic FALL_THROUGH_SELECT, // Timing mode strap.
  output logic [`FTF_DATA_W-1:0] READ_DATA_BUS, // Head word.
  output logic OR_N, // Output ready, active low.
  output logic INPUT_READY_N, // Input ready, active low.
  output logic ALMOST_EMPTY_FLAG_N, // Almost-empty flag, active low.
  output logic HALF_FULL_FLAG_N, // Half-full flag, active low.
  output logic ALMOST_FULL_FLAG_N, // Almost-full flag, active low.
  output logic IRQ, // Interrupt, active high level.
  input wire logic [7:0] S_AXI_AWADDR, // AXI write address.
  input wire logic S_AXI_AWVALID, // AXI write address valid.
  output logic S_AXI_AWREADY, // AXI write address ready.
  input wire logic [31:0] S_AXI_WDATA, // AXI write data.
  input wire logic [3:0] S_AXI_WSTRB, // AXI write strobes.
  input wire logic S_AXI_WVALID, // AXI write data valid.
  output logic S_AXI_WREADY, // AXI write data ready.
  output logic [1:0] S_AXI_BRESP, // AXI write response.
  output logic S_AXI_BVALID, // AXI write response valid.
  input wire logic S_AXI_BREADY, // AXI write response ready.
  input wire logic [7:0] S_AXI_ARADDR, // AXI read address.
  input wire logic S_AXI_ARVALID, // AXI read address valid.
  output logic S_AXI_ARREADY, // AXI read address ready.
  output logic [31:0] S_AXI_RDATA, // AXI read data.
  output logic [1:0] S_AXI_RRESP, // AXI read response.
  output logic S_AXI_RVALID, // AXI read data valid.
  input wire logic S_AXI_RREADY // AXI read data ready.
);

  // Pin synchronisers: three stages, a level counts once stages two and three agree.
  ftf_pins_t pin_raw, s1_q, s2_q, s3_q, lvl_q;
  wire ftf_pins_t lvl_d;
  assign pin_raw = '{WCLK, RCLK, WEN_N, REN_N, OFFSET_LOAD_SELECT, DEFAULT_OFFSET_SEL_HI,
                     DEFAULT_OFFSET_SEL_LO, FALL_THROUGH_SELECT, WRITE_DATA_BUS};

  for (genvar i = 0; i < `FTF_PIN_W; i++) begin : g_lvl
    assign lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
  end

  // No reset here: the straps must be seen while reset is held.
  always_ff @(posedge CLK_SYS) begin
    s1_q <= pin_raw;
    s2_q <= s1_q;
    s3_q <= s2_q;
    lvl_q <= lvl_d;
  end

  logic wclk_ev, rclk_ev;
  assign wclk_ev = RST_N & lvl_d.wclk & ~lvl_q.wclk;
  assign rclk_ev = RST_N & lvl_d.rclk & ~lvl_q.rclk;

  // Straps caught during master reset.
  ftf_straps_t strap_q, strap_d;
  logic [2:0] sel;
  logic [`FTF_OFS_W-1:0] ofs_pick;

  always_comb begin
    sel = {s3_q.offset_load_select, s3_q.default_offset_sel_hi, s3_q.default_offset_sel_lo};
    case (sel) // see RQ8
      3'h0: ofs_pick = `FTF_OFS_LLL;
      3'h1: ofs_pick = `FTF_OFS_LLH;
      3'h2: ofs_pick = `FTF_OFS_LHL;
      3'h3: ofs_pick = `FTF_OFS_LHH;
      3'h4: ofs_pick = `FTF_OFS_HLL;
      3'h5: ofs_pick = `FTF_OFS_HLH;
      3'h6: ofs_pick = `FTF_OFS_HHL;
      default: ofs_pick = `FTF_OFS_HHH;
    endcase
    strap_d = strap_q;
    if (!RST_N) begin
      strap_d.fall_through_mode = s3_q.fall_through_select; // see RQ10
      strap_d.serial_load_mode = s3_q.offset_load_select; // see RQ13
      strap_d.offset = ofs_pick; // see RQ8
    end
  end

  always_ff @(posedge CLK_SYS) begin
    strap_q <= strap_d;
  end

  // Writes and reads are taken only while the load pin is high.
  logic load_ok;
  assign load_ok = lvl_q.offset_load_select; // see RQ9

  // Pointers and their gray-coded copies crossing to the far side.
  logic [`FTF_PTR_W-1:0] wptr_q, wptr_d, cptr_q, cptr_d, fptr_q, fptr_d;
  logic [`FTF_PTR_W-1:0] wg_q, cg_q, wg_s1_q, wg_s2_q, cg_s1_q, cg_s2_q;
  logic [`FTF_PTR_W-1:0] cnt_w, cnt_r, wptr_r;
  logic full_w, wr_try, wr_ok, rd_try, rd_ok, fetch, load_q, out_valid_q, out_valid_d;
  logic [`FTF_DATA_W-1:0] mem_rdata, q_q, q_d;

  assign wptr_r = ftf_from_gray(wg_s2_q);
  assign cnt_w = wptr_q - ftf_from_gray(cg_s2_q); // see RQ15
  assign cnt_r = wptr_r - cptr_q; // see RQ15
  assign full_w = (cnt_w >= `FTF_DEPTH); // see RQ7
  assign wr_try = wclk_ev & ~lvl_d.wen_n & load_ok;
  assign wr_ok = wr_try & ~full_w; // see RQ1 see RQ6
  assign rd_try = rclk_ev & ~lvl_d.ren_n & load_ok;
  assign rd_ok = rd_try & out_valid_q; // see RQ14
  // Fetch from memory without any read enable when the head is free.
  assign fetch = rclk_ev & ~load_q & (fptr_q != wptr_r) & (~out_valid_q | rd_ok); // see RQ11

  always_comb begin
    wptr_d = wr_ok ? wptr_q + 1'b1 : wptr_q;
    cptr_d = rd_ok ? cptr_q + 1'b1 : cptr_q;
    fptr_d = fetch ? fptr_q + 1'b1 : fptr_q;
    out_valid_d = out_valid_q;
    q_d = q_q;
    if (load_q) begin
      out_valid_d = 1'b1; // see RQ2
      q_d = mem_rdata;
    end else if (rd_ok && !fetch) begin
      out_valid_d = 1'b0; // see RQ14
    end
  end

  // Write-pointer copies advance with read clock rises, read-pointer copies with write clock rises.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      wptr_q <= '0;
      cptr_q <= '0;
      fptr_q <= '0;
      wg_q <= '0;
      cg_q <= '0;
      wg_s1_q <= '0;
      wg_s2_q <= '0;
      cg_s1_q <= '0;
      cg_s2_q <= '0;
      load_q <= 1'b0;
      out_valid_q <= 1'b0;
      q_q <= '0;
    end else begin
      wptr_q <= wptr_d;
      cptr_q <= cptr_d;
      fptr_q <= fptr_d;
      wg_q <= ftf_to_gray(wptr_d);
      cg_q <= ftf_to_gray(cptr_d);
      if (rclk_ev) begin
        wg_s1_q <= wg_q; // see RQ12
        wg_s2_q <= wg_s1_q;
      end
      if (wclk_ev) begin
        cg_s1_q <= cg_q; // see RQ12
        cg_s2_q <= cg_s1_q;
      end
      load_q <= fetch;
      out_valid_q <= out_valid_d;
      q_q <= q_d;
    end
  end

  ftf_mem u_mem (
    .clk(CLK_SYS),
    .we(wr_ok),
    .waddr(wptr_q[`FTF_ADDR_W-1:0]),
    .wdata(lvl_d.write_data_bus),
    .re(fetch),
    .raddr(fptr_q[`FTF_ADDR_W-1:0]),
    .rdata(mem_rdata)
  );

  // Flags are registered from the synchronised counts and out_valid_q, so none can glitch.
  ftf_flags_t flg_q, flg_d;
  logic [`FTF_PTR_W-1:0] ofs_w;
  assign ofs_w = {1'b0, strap_q.offset};

  always_comb begin
    flg_d.or_n = ~out_valid_q; // see RQ2 see RQ14
    flg_d.input_ready_n = full_w; // see RQ6
    flg_d.almost_empty_flag_n = (cnt_r >= ofs_w + `FTF_AE_ADD); // see RQ3
    flg_d.half_full_flag_n = ~(cnt_w >= `FTF_HALF_MARK); // see RQ4
    flg_d.almost_full_flag_n = ~(cnt_w >= `FTF_DEPTH - ofs_w); // see RQ5
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      flg_q <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    end else begin
      flg_q <= flg_d;
    end
  end

  assign {OR_N, INPUT_READY_N, ALMOST_EMPTY_FLAG_N, HALF_FULL_FLAG_N, ALMOST_FULL_FLAG_N} = flg_q;
  assign READ_DATA_BUS = q_q;

  // Register slave; events are sticky and a written one clears, an event wins.
  logic [`FTF_EV_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d, aw_hs, ar_hs, wlo;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;

  assign aw_hs = S_AXI_AWVALID & S_AXI_WVALID & ~bvalid_q;
  assign ar_hs = S_AXI_ARVALID & ~rvalid_q;
  assign wlo = aw_hs & S_AXI_WSTRB[0];

  always_comb begin
    ev = '0;
    ev[`FTF_EV_WR_REJ] = wr_try & full_w; // see RQ6
    ev[`FTF_EV_RD_REJ] = rd_try & ~out_valid_q; // see RQ14
    ev[`FTF_EV_FULL] = flg_d.input_ready_n & ~flg_q.input_ready_n;
    ev[`FTF_EV_EMPTY] = flg_d.or_n & ~flg_q.or_n;
    stat_d = stat_q;
    mask_d = mask_q;
    if (wlo && S_AXI_AWADDR == `FTF_REG_STATUS) begin
      stat_d = stat_q & ~S_AXI_WDATA[`FTF_EV_W-1:0];
    end
    if (wlo && S_AXI_AWADDR == `FTF_REG_MASK) begin
      mask_d = S_AXI_WDATA[`FTF_EV_W-1:0];
    end
    stat_d = stat_d | ev;
    bvalid_d = aw_hs | (bvalid_q & ~S_AXI_BREADY);
    bresp_d = bresp_q;
    if (aw_hs) begin
      bresp_d = (S_AXI_AWADDR == `FTF_REG_STATUS || S_AXI_AWADDR == `FTF_REG_MASK)
                ? `FTF_RESP_OKAY : `FTF_RESP_SLVERR;
    end
    rvalid_d = ar_hs | (rvalid_q & ~S_AXI_RREADY);
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_hs) begin
      rresp_d = `FTF_RESP_OKAY;
      case (S_AXI_ARADDR)
        `FTF_REG_STATUS: rdata_d = {28'h000_0000, stat_q};
        `FTF_REG_MASK: rdata_d = {28'h000_0000, mask_q};
        `FTF_REG_CONFIG: rdata_d = {5'h00, strap_q.offset, 14'h0000,
                                    strap_q.serial_load_mode, strap_q.fall_through_mode};
        `FTF_REG_LEVEL: rdata_d = {11'h000, flg_q, 4'h0, cnt_r};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = `FTF_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      stat_q <= '0;
      mask_q <= `FTF_RST_MASK;
      bvalid_q <= 1'b0;
      bresp_q <= `FTF_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= `FTF_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign S_AXI_AWREADY = aw_hs;
  assign S_AXI_WREADY = aw_hs;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = ~rvalid_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign IRQ = |(stat_q & mask_q);

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence s_fall_through;
    load_q ##2 !OR_N;
  endsequence

  a_write_store: assert property (wr_ok |=> wptr_q == $past(wptr_q) + 1'b1) // see RQ1
    else $error("Accepted write did not advance the write pointer.");
  a_ready_first: assert property ($rose(out_valid_q) |=> !OR_N) // see RQ2
    else $error("Output ready did not go low after the first word.");
  a_empty_level: assert property ((cnt_r >= ofs_w + 12'h002) |=> ALMOST_EMPTY_FLAG_N) // see RQ3
    else $error("Almost-empty flag low above offset plus two.");
  a_half_level: assert property ((cnt_w == 12'h402) |=> !HALF_FULL_FLAG_N) // see RQ4
    else $error("Half-full flag high at 1026 words.");
  a_full_level: assert property ((cnt_w < 12'h801 - ofs_w) |=> ALMOST_FULL_FLAG_N) // see RQ5
    else $error("Almost-full flag low below depth minus offset.");
  a_write_block: assert property (wr_try && full_w |=> wptr_q == $past(wptr_q)) // see RQ6
    else $error("Write taken while full.");
  a_depth_cap: assert property (cnt_w <= 12'h801 && (cnt_w == 12'h801) == full_w) // see RQ7
    else $error("Fill count passed 2049 words.");
  a_fetch_path: assert property (fetch |=> s_fall_through) // see RQ11
    else $error("Fetched word did not reach the read bus in three cycles.");
  a_ready_steady: assert property (rd_ok && fetch |=> out_valid_q) // see RQ14
    else $error("Output ready dropped between two words.");
  a_empty_read: assert property (rd_try && !out_valid_q |=> cptr_q == $past(cptr_q)) // see RQ14
    else $error("Read on empty FIFO moved the read pointer.");

endmodule
`default_nettype wire

// >>> verification/ftf_port_model.sv
// Producer and consumer logic standing at the FIFO's write and read pins.
// Assumes one bench process calls cycle(); both clocks stand still between calls.
`timescale 1ns/100ps
`default_nettype none
`include "ftf_defs.svh"

module ftf_port_model
  import ftf_pkg::*;
(
  input wire logic clk, // System clock used for pacing.
  output logic wclk, // Write clock pin.
  output logic wen_n, // Write enable, active low.
  output logic [`FTF_DATA_W-1:0] wdata, // Write data.
  output logic rclk, // Read clock pin.
  output logic ren_n // Read enable, active low.
);
  initial begin
    wclk = 1'b0;
    rclk = 1'b0;
    wen_n = 1'b1;
    ren_n = 1'b1;
    wdata = '0;
  end

  // One 90 ns period for each selected clock, 10 ns longer per gap step; a nonzero gap makes a slow partner.
  task automatic cycle(input logic wk, input logic rk, input logic we, input logic re,
                       input logic [`FTF_DATA_W-1:0] d, input int gap);
    repeat (gap + 1) @(posedge clk);
    wen_n <= ~we;
    ren_n <= ~re;
    if (we) begin
      wdata <= d;
    end
    repeat (4) @(posedge clk);
    wclk <= wk;
    rclk <= rk;
    repeat (4) @(posedge clk);
    wclk <= 1'b0;
    rclk <= 1'b0;
    wen_n <= 1'b1;
    ren_n <= 1'b1;
    if (we) begin
      wdata <= ~d; // A released bus shows the inverse, so a late sample cannot pass.
    end
  endtask
endmodule
`default_nettype wire

// >>> verification/tb_fall_through_fifo_status_flags.sv
// Self-checking bench of the fall-through FIFO flags: straps, fill, drain, registers.
// Assumes the port model at the pins and AXI4-Lite timing as the design states it.
`timescale 1ns/100ps
`default_nettype none
`include "ftf_defs.svh"

module tb_fall_through_fifo_status_flags
  import ftf_pkg::*;
;
  localparam int DEPTH = 2049;
  localparam int OFS = 7;
  localparam int HALF = DEPTH / 2 + 2;
  logic clk_sys, rst_n = 1'b0, load_sel = 1'b0, sel_hi = 1'b0, sel_lo = 1'b0, fts = 1'b1;
  logic wclk, wen_n, rclk, ren_n, or_n, in_rdy_n, ae_n, half_n, af_n, irq;
  logic [`FTF_DATA_W-1:0] wdata, rd_bus;
  logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
  logic [31:0] w_data = 32'h0000_0000, r_data;
  logic [3:0] w_strb = 4'hF;
  logic [1:0] b_resp, r_resp;
  logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
  int fail_count = 0, check_count = 0;
  logic [10:0] ofs_tab [8] = '{11'h07F, 11'h0FF, 11'h1FF, 11'h03F, 11'h3FF, 11'h00F,
                              11'h01F, 11'h007};

  ftf_fifo uut (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .WCLK(wclk), .WEN_N(wen_n), .WRITE_DATA_BUS(wdata),
    .RCLK(rclk), .REN_N(ren_n), .OFFSET_LOAD_SELECT(load_sel), .DEFAULT_OFFSET_SEL_HI(sel_hi),
    .DEFAULT_OFFSET_SEL_LO(sel_lo), .FALL_THROUGH_SELECT(fts), .READ_DATA_BUS(rd_bus),
    .OR_N(or_n), .INPUT_READY_N(in_rdy_n), .ALMOST_EMPTY_FLAG_N(ae_n), .HALF_FULL_FLAG_N(half_n),
    .ALMOST_FULL_FLAG_N(af_n), .IRQ(irq), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid),
    .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb),
    .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp),
    .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr),
    .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data),
    .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready)
  );
  ftf_port_model pm (
    .clk(clk_sys), .wclk(wclk), .wen_n(wen_n), .wdata(wdata), .rclk(rclk), .ren_n(ren_n)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic summarize;
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic timeout;
    fail_count++;
    $display("unexpected bus answer: expected handshake, seen none");
    summarize();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge clk_sys);
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!(aw_ready === 1'b1 && w_ready === 1'b1) && n < 50);
    aw_valid <= 1'b0;
    w_valid <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (b_valid !== 1'b1 && n < 100);
    b_ready <= 1'b0;
    if (n >= 100) begin
      timeout();
    end
    chk("write response", 32'(er), 32'(b_resp));
  endtask

  task automatic reg_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                         input logic [1:0] er);
    int n = 0;
    @(posedge clk_sys);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ar_ready !== 1'b1 && n < 50);
    ar_valid <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (r_valid !== 1'b1 && n < 100);
    r_ready <= 1'b0;
    if (n >= 100) begin
      timeout();
    end
    chk(what, exp, r_data);
    chk("read response", 32'(er), 32'(r_resp));
  endtask

  task automatic do_reset(input logic l, input logic h, input logic o);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    load_sel <= l;
    sel_hi <= h;
    sel_lo <= o;
    fts <= o;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    load_sel <= 1'b1;
    @(posedge clk_sys);
  endtask

  function automatic logic [`FTF_DATA_W-1:0] wd(input int k);
    return `FTF_DATA_W'(k) ^ 18'h2_A5A5;
  endfunction

  function automatic bit at_edge(input int c);
    return c inside {0, 1, OFS + 1, OFS + 2, HALF - 1, HALF, DEPTH - OFS - 1, DEPTH - OFS,
                     DEPTH - 1, DEPTH};
  endfunction

  // Idle ticks of both clocks let the crossing counts agree before flags are judged.
  task automatic check_at(input int c);
    logic [4:0] f;
    f = {c == 0, c >= DEPTH, c >= OFS + 2, c < HALF, c < DEPTH - OFS};
    repeat (3) pm.cycle(1'b1, 1'b1, 1'b0, 1'b0, '0, 0);
    repeat (8) @(posedge clk_sys);
    chk("flags", 32'(f), 32'({or_n, in_rdy_n, ae_n, half_n, af_n}));
    reg_chk("level", 8'h0C, {11'h000, f, 4'h0, 12'(c)}, 2'h0);
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      do_reset(i[2], i[1], i[0]);
      chk("reset flags", 32'h0000_0013, 32'({or_n, in_rdy_n, ae_n, half_n, af_n}));
      chk("reset data", 32'h0000_0000, 32'(rd_bus));
      reg_chk("config", 8'h08, {5'h00, ofs_tab[i], 14'h0000, i[2], i[0]}, 2'h0);
    end
    chk("irq", 32'h0000_0000, 32'(irq));
    reg_chk("mask", 8'h04, 32'h0000_0000, 2'h0);
    reg_chk("status", 8'h00, 32'h0000_0000, 2'h0);
    reg_chk("unmapped", 8'h10, 32'h0000_0000, 2'h2);
    axi_wr(8'h10, 32'hFFFF_FFFF, 2'h2);
    w_strb <= 4'hE;
    axi_wr(8'h04, 32'h0000_000F, 2'h0);
    w_strb <= 4'hF;
    reg_chk("mask lane", 8'h04, 32'h0000_0000, 2'h0);
    $display("test straps done");
    pm.cycle(1'b1, 1'b0, 1'b1, 1'b0, wd(0), 0);
    repeat (2) pm.cycle(1'b0, 1'b1, 1'b0, 1'b0, '0, 0);
    repeat (8) @(posedge clk_sys);
    chk("ready early", 32'h0000_0001, 32'(or_n));
    pm.cycle(1'b0, 1'b1, 1'b0, 1'b0, '0, 0);
    repeat (8) @(posedge clk_sys);
    chk("ready", 32'h0000_0000, 32'(or_n));
    chk("first word", 32'(wd(0)), 32'(rd_bus));
    check_at(1);
    $display("test first word done");
    for (int c = 2; c <= DEPTH; c++) begin
      pm.cycle(1'b1, 1'b0, 1'b1, 1'b0, wd(c - 1), c % 2);
      if (at_edge(c)) begin
        check_at(c);
      end
    end
    pm.cycle(1'b1, 1'b0, 1'b1, 1'b0, wd(DEPTH), 0);
    check_at(DEPTH);
    reg_chk("status", 8'h00, 32'h0000_0005, 2'h0);
    chk("irq", 32'h0000_0000, 32'(irq));
    axi_wr(8'h04, 32'h0000_0001, 2'h0);
    chk("irq", 32'h0000_0001, 32'(irq));
    axi_wr(8'h00, 32'h0000_0001, 2'h0);
    chk("irq", 32'h0000_0000, 32'(irq));
    reg_chk("status", 8'h00, 32'h0000_0004, 2'h0);
    $display("test fill done");
    for (int c = DEPTH; c >= 1; c--) begin
      chk("head word", 32'(wd(DEPTH - c)), 32'(rd_bus));
      pm.cycle(1'b0, 1'b1, 1'b0, 1'b1, '0, c % 3);
      repeat (4) @(posedge clk_sys);
      if (at_edge(c - 1)) begin
        check_at(c - 1);
      end
    end
    pm.cycle(1'b0, 1'b1, 1'b0, 1'b1, '0, 0);
    check_at(0);
    reg_chk("status", 8'h00, 32'h0000_000E, 2'h0);
    chk("irq", 32'h0000_0000, 32'(irq));
    axi_wr(8'h04, 32'h0000_0002, 2'h0);
    chk("irq", 32'h0000_0001, 32'(irq));
    axi_wr(8'h00, 32'h0000_000F, 2'h0);
    chk("irq", 32'h0000_0000, 32'(irq));
    reg_chk("status", 8'h00, 32'h0000_0000, 2'h0);
    $display("test drain done");
    summarize();
  end
endmodule
`default_nettype wire
